// ==== logic/inertial_event_cfg.svh ====
// Register offsets, reset values and field positions of the inertial event detector
// Behaviour
// - Motion ack read clears latched motion source
// - Motion threshold is high byte then low
// - Threshold 7FFFh equals full-scale acceleration
// - Duration counts output samples at chosen rate
// - Events shorter than duration raise nothing
// - Duration zero fires on first true sample
// - Tilt config bits: irq, latch, ZH..XL
// - Irq enable raises tilt irq on change
// - Latch select holds captured tilt status
// - Tilt ack read clears irq, reloads live source flags
// - Positive enable flags axis above threshold
// - Negative enable flags axis below threshold
// - Inner, outer thresholds are 16-bit pairs
// - Above outer while positive means high
// - Beyond outer while negative means low
// - Below inner clears high and low
// - Inner above outer uses outer only
// - Tilt active bit sets on enabled change
// - Tilt ack refreshes source, clears irq
// - Combine select picks OR or AND
// - Motion active bit drives motion irq
`ifndef INERTIAL_EVENT_CFG_SVH
`define INERTIAL_EVENT_CFG_SVH

// Register offsets
`define ADDR_MOTION_SOURCE    8'h31
`define ADDR_MOTION_ACK       8'h32
`define ADDR_MOTION_THR_LOW   8'h34
`define ADDR_MOTION_THR_HIGH  8'h35
`define ADDR_MOTION_MIN_DUR   8'h36
`define ADDR_TILT_CONFIG      8'h38
`define ADDR_TILT_SOURCE      8'h39
`define ADDR_TILT_ACK         8'h3A
`define ADDR_INNER_THR_LOW    8'h3C
`define ADDR_INNER_THR_HIGH   8'h3D
`define ADDR_OUTER_THR_LOW    8'h3E
`define ADDR_OUTER_THR_HIGH   8'h3F

// Reset values and the fixed ack and unmapped read values
`define RESET_REG8            8'h00
`define RESET_THR16           16'h0000
`define RESET_DUR_COUNT       8'h00
`define ACK_READ_VALUE        8'h00
`define UNMAPPED_READ_VALUE   8'h00

// Field positions of the tilt configuration register
`define TILT_CFG_IRQ_EN_BIT   7
`define TILT_CFG_LATCH_BIT    6

// Full-scale code of a threshold
`define THR_FULL_SCALE        16'h7FFF

`endif

// ==== logic/inertial_event_pkg.sv ====
// Types shared by the inertial event detector files
package inertial_event_pkg;

  // Three axes of one output sample, two's complement
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_type;

  // Motion event configuration bits
  typedef struct packed {
    logic combine_and_or_select;
    logic latch_request_select;
    logic zHigh;
    logic zLow;
    logic yHigh;
    logic yLow;
    logic xHigh;
    logic xLow;
  } motionCfg_type;

  // Tilt detect configuration register layout, bit 7 first
  typedef struct packed {
    logic direction_change_irq_enable;
    logic latchSelect;
    logic z_positive_enable;
    logic z_negative_enable;
    logic y_positive_enable;
    logic y_negative_enable;
    logic x_positive_enable;
    logic x_negative_enable;
  } tiltCfg_type;

  // Source register layout shared by motion and tilt
  typedef struct packed {
    logic       unused;
    logic       interrupt_active;
    logic [5:0] flags;
  } source_type;

  // One register access from the serial front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } regReq_type;

  // Per-axis tilt zone state
  typedef enum logic [2:0] {
    TILT_NEUTRAL = 3'b001,
    TILT_HIGH    = 3'b010,
    TILT_LOW     = 3'b100
  } axisTilt_type;

  // Magnitude of a two's complement sample, one bit wider
  function automatic logic [16:0] absMag(input logic [15:0] value);
    logic [16:0] ext;
    ext = {value[15], value};
    absMag = value[15] ? 17'(~ext + 17'h0_0001) : ext;
  endfunction

endpackage

// ==== logic/tilt_axis_classifier.sv ====
// One axis of the tilt detector with inner/outer hysteresis
`timescale 1ns/1ps
`include "inertial_event_cfg.svh"

module tilt_axis_classifier
  import inertial_event_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sample in
  input  wire logic         sampleValid,
  input  wire logic [15:0]  accel,
  // Thresholds
  input  wire logic [15:0]  outerThr,
  input  wire logic [15:0]  innerThr,
  // Zone out
  output axisTilt_type      tilt
);

  axisTilt_type tilt_q;
  axisTilt_type tilt_d;
  logic [16:0]  mag;
  logic [15:0]  effInner;

  // Zone update; between the thresholds the old zone holds
  always_comb begin
    mag      = absMag(accel);
    effInner = (innerThr > outerThr) ? outerThr : innerThr;
    tilt_d   = tilt_q;
    if (sampleValid) begin
      if (mag > {1'b0, outerThr}) begin
        tilt_d = accel[15] ? TILT_LOW : TILT_HIGH;
      end else if (mag < {1'b0, effInner}) begin
        tilt_d = TILT_NEUTRAL;
      end
    end
  end

  // Zone register
  always_ff @(posedge clk) begin
    if (rst) begin
      tilt_q <= TILT_NEUTRAL;
    end else begin
      tilt_q <= tilt_d;
    end
  end

  assign tilt = tilt_q;

endmodule // tilt_axis_classifier

// ==== logic/inertial_event_detector.sv ====
// Free-fall/wake-up and tilt direction event logic with its registers
`timescale 1ns/1ps
`include "inertial_event_cfg.svh"

module inertial_event_detector
  import inertial_event_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Register access from the serial front end
  input  regReq_type        regReq,
  output logic [7:0]        regRdData,
  // Output samples at the decimated rate
  input  wire logic         sampleValid,
  input  sample_type        sample,
  // Motion event configuration held elsewhere
  input  motionCfg_type     motionCfg,
  // Interrupt lines
  output logic              motionIrq,
  output logic              tiltIrq
);

  // Register file state
  logic [7:0]    thrLow_q;
  logic [7:0]    thrLow_d;
  logic [7:0]    thrHigh_q;
  logic [7:0]    thrHigh_d;
  logic [7:0]    minDur_q;
  logic [7:0]    minDur_d;
  tiltCfg_type   tiltCfg_q;
  tiltCfg_type   tiltCfg_d;
  logic [7:0]    innerLow_q;
  logic [7:0]    innerLow_d;
  logic [7:0]    innerHigh_q;
  logic [7:0]    innerHigh_d;
  logic [7:0]    outerLow_q;
  logic [7:0]    outerLow_d;
  logic [7:0]    outerHigh_q;
  logic [7:0]    outerHigh_d;
  logic [7:0]    rdData_q;
  logic [7:0]    rdData_d;

  // Motion detector state
  source_type    motionSrc_q;
  source_type    motionSrc_d;
  logic [7:0]    durCount_q;
  logic [7:0]    durCount_d;

  // Tilt detector state
  source_type    tiltSrc_q;
  source_type    tiltSrc_d;
  logic [5:0]    prevDir_q;
  logic [5:0]    prevDir_d;
  logic          tiltEval_q;
  logic          tiltEval_d;

  // Threshold words built from their byte pairs
  logic [15:0]   motionThr;
  logic [15:0]   innerThr;
  logic [15:0]   outerThr;

  // Acknowledge strobes, one cycle wide
  logic          motionAckRead;
  logic          tiltAckRead;

  // Per-axis views of the current sample
  logic [16:0]   axisMag [3];
  logic [15:0]   axisVal [3];
  axisTilt_type  axisTilt [3];

  // Motion combine and duration filter
  logic [5:0]    motionRaw;
  logic [5:0]    motionEnable;
  logic [5:0]    motionEvt;
  logic          motionCond;
  logic [8:0]    durNext;
  logic          motionConfirmed;

  // Tilt change detection
  logic [5:0]    tiltEnable;
  logic [5:0]    tiltLive;
  logic          tiltChanged;

  // Threshold pairs, high byte on top; full scale 7FFFh matches the
  // sample scale, so the comparisons need no rescaling per range
  assign motionThr = {thrHigh_q, thrLow_q};
  assign innerThr  = {innerHigh_q, innerLow_q};
  assign outerThr  = {outerHigh_q, outerLow_q};

  // Acknowledge strobes are decoded from the read itself
  assign motionAckRead = regReq.rd && (regReq.addr == `ADDR_MOTION_ACK);
  assign tiltAckRead   = regReq.rd && (regReq.addr == `ADDR_TILT_ACK);

  assign axisVal[0] = sample.x;
  assign axisVal[1] = sample.y;
  assign axisVal[2] = sample.z;

  // Per-axis magnitude compare and tilt zone
  for (genvar axis = 0; axis < 3; axis++) begin : gAxis
    assign axisMag[axis]         = absMag(axisVal[axis]);
    assign motionRaw[2*axis + 1] = axisMag[axis] > {1'b0, motionThr};
    assign motionRaw[2*axis]     = axisMag[axis] < {1'b0, motionThr};
    assign tiltLive[2*axis + 1]  = (axisTilt[axis] == TILT_HIGH) && tiltEnable[2*axis + 1];
    assign tiltLive[2*axis]      = (axisTilt[axis] == TILT_LOW) && tiltEnable[2*axis];

    tilt_axis_classifier uClassifier (
      .clk         (clk),
      .rst         (rst),
      .sampleValid (sampleValid),
      .accel       (axisVal[axis]),
      .outerThr    (outerThr),
      .innerThr    (innerThr),
      .tilt        (axisTilt[axis])
    );
  end

  // Enables in source flag order Z-high down to X-low
  assign motionEnable = {motionCfg.zHigh,
                         motionCfg.zLow,
                         motionCfg.yHigh,
                         motionCfg.yLow,
                         motionCfg.xHigh,
                         motionCfg.xLow};
  // Tilt enables mask both the flags and the change compare
  assign tiltEnable   = {tiltCfg_q.z_positive_enable,
                         tiltCfg_q.z_negative_enable,
                         tiltCfg_q.y_positive_enable,
                         tiltCfg_q.y_negative_enable,
                         tiltCfg_q.x_positive_enable,
                         tiltCfg_q.x_negative_enable};

  // Combined motion condition; AND with nothing enabled never fires
  always_comb begin
    motionEvt = motionRaw & motionEnable;
    if (motionCfg.combine_and_or_select) begin
      motionCond = (motionEnable != 6'h00) && (motionEvt == motionEnable);
    end else begin
      motionCond = |motionEvt;
    end
  end

  // Register writes; reads of the ack addresses store nothing
  always_comb begin
    thrLow_d    = thrLow_q;
    thrHigh_d   = thrHigh_q;
    minDur_d    = minDur_q;
    tiltCfg_d   = tiltCfg_q;
    innerLow_d  = innerLow_q;
    innerHigh_d = innerHigh_q;
    outerLow_d  = outerLow_q;
    outerHigh_d = outerHigh_q;
    if (regReq.wr) begin
      unique case (regReq.addr)
        `ADDR_MOTION_THR_LOW:  thrLow_d    = regReq.data;
        `ADDR_MOTION_THR_HIGH: thrHigh_d   = regReq.data;
        `ADDR_MOTION_MIN_DUR:  minDur_d    = regReq.data;
        `ADDR_TILT_CONFIG:     tiltCfg_d   = tiltCfg_type'(regReq.data);
        `ADDR_INNER_THR_LOW:   innerLow_d  = regReq.data;
        `ADDR_INNER_THR_HIGH:  innerHigh_d = regReq.data;
        `ADDR_OUTER_THR_LOW:   outerLow_d  = regReq.data;
        `ADDR_OUTER_THR_HIGH:  outerHigh_d = regReq.data;
        default: ;
      endcase
    end
  end

  // Read mux, registered so the data leaves a flip-flop
  // Source registers read back here; writes to them are dropped
  always_comb begin
    rdData_d = rdData_q;
    if (regReq.rd) begin
      unique case (regReq.addr)
        `ADDR_MOTION_SOURCE:   rdData_d = motionSrc_q;
        `ADDR_MOTION_ACK:      rdData_d = `ACK_READ_VALUE;
        `ADDR_MOTION_THR_LOW:  rdData_d = thrLow_q;
        `ADDR_MOTION_THR_HIGH: rdData_d = thrHigh_q;
        `ADDR_MOTION_MIN_DUR:  rdData_d = minDur_q;
        `ADDR_TILT_CONFIG:     rdData_d = tiltCfg_q;
        `ADDR_TILT_SOURCE:     rdData_d = tiltSrc_q;
        `ADDR_TILT_ACK:        rdData_d = `ACK_READ_VALUE;
        `ADDR_INNER_THR_LOW:   rdData_d = innerLow_q;
        `ADDR_INNER_THR_HIGH:  rdData_d = innerHigh_q;
        `ADDR_OUTER_THR_LOW:   rdData_d = outerLow_q;
        `ADDR_OUTER_THR_HIGH:  rdData_d = outerHigh_q;
        default:               rdData_d = `UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // Register file flops, all cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      thrLow_q    <= `RESET_REG8;
      thrHigh_q   <= `RESET_REG8;
      minDur_q    <= `RESET_REG8;
      tiltCfg_q   <= tiltCfg_type'(`RESET_REG8);
      innerLow_q  <= `RESET_REG8;
      innerHigh_q <= `RESET_REG8;
      outerLow_q  <= `RESET_REG8;
      outerHigh_q <= `RESET_REG8;
      rdData_q    <= `RESET_REG8;
    end else begin
      thrLow_q    <= thrLow_d;
      thrHigh_q   <= thrHigh_d;
      minDur_q    <= minDur_d;
      tiltCfg_q   <= tiltCfg_d;
      innerLow_q  <= innerLow_d;
      innerHigh_q <= innerHigh_d;
      outerLow_q  <= outerLow_d;
      outerHigh_q <= outerHigh_d;
      rdData_q    <= rdData_d;
    end
  end

  // Duration filter; the count is of output samples, so the decimation
  // rate sets its time base without any extra timer here
  always_comb begin
    durNext         = {1'b0, durCount_q} + 9'h001;
    durCount_d      = durCount_q;
    motionConfirmed = 1'b0;
    if (sampleValid) begin
      if (motionCond) begin
        durCount_d      = durNext[8] ? durCount_q : durNext[7:0];  // Saturates
        motionConfirmed = durNext >= {1'b0, minDur_q};
      end else begin
        durCount_d = `RESET_DUR_COUNT;
      end
    end
  end

  // Motion source; a sample in the ack cycle wins over the clear
  // Latched: flags freeze with the active bit until the ack read
  always_comb begin
    motionSrc_d = motionSrc_q;
    if (motionAckRead && motionCfg.latch_request_select) begin
      motionSrc_d = source_type'(`RESET_REG8);
    end
    if (sampleValid) begin
      if (!motionCfg.latch_request_select) begin
        motionSrc_d.interrupt_active = motionConfirmed;
        motionSrc_d.flags            = motionEvt;
      end else if (!motionSrc_d.interrupt_active) begin
        motionSrc_d.interrupt_active = motionConfirmed;
        motionSrc_d.flags            = motionEvt;
      end
    end
  end

  // Motion detector flops
  always_ff @(posedge clk) begin
    if (rst) begin
      motionSrc_q <= source_type'(`RESET_REG8);
      durCount_q  <= `RESET_DUR_COUNT;
    end else begin
      motionSrc_q <= motionSrc_d;
      durCount_q  <= durCount_d;
    end
  end

  // Tilt zones settle one cycle after the sample, so evaluate then;
  // the compare is against the last masked view, so a config write
  // that masks a flagged axis shows up as a change on the next sample
  assign tiltEval_d  = sampleValid;
  assign tiltChanged = tiltEval_q && (tiltLive != prevDir_q);

  // Tilt source; ack refreshes to live, a change in that cycle still sets
  always_comb begin
    tiltSrc_d = tiltSrc_q;
    prevDir_d = prevDir_q;
    if (tiltAckRead) begin
      tiltSrc_d.interrupt_active = 1'b0;
      tiltSrc_d.flags            = tiltLive;
    end
    if (tiltEval_q) begin
      prevDir_d = tiltLive;
      if (!tiltCfg_q.latchSelect) begin
        tiltSrc_d.flags = tiltLive;
      end else if (tiltChanged && !tiltSrc_q.interrupt_active) begin
        tiltSrc_d.flags = tiltLive;
      end
      if (tiltChanged) begin
        tiltSrc_d.interrupt_active = 1'b1;
      end
    end
  end

  // Tilt detector flops
  always_ff @(posedge clk) begin
    if (rst) begin
      tiltSrc_q  <= source_type'(`RESET_REG8);
      prevDir_q  <= 6'h00;
      tiltEval_q <= 1'b0;
    end else begin
      tiltSrc_q  <= tiltSrc_d;
      prevDir_q  <= prevDir_d;
      tiltEval_q <= tiltEval_d;
    end
  end

  // Outputs
  assign regRdData = rdData_q;
  assign motionIrq = motionSrc_q.interrupt_active;
  assign tiltIrq   = tiltSrc_q.interrupt_active
                     && tiltCfg_q.direction_change_irq_enable;

endmodule // inertial_event_detector

// ==== test/inertial_event_detector_properties.sv ====
// Port checker of the inertial event detector
`timescale 1ns/1ps
module inertial_event_detector_properties
  import inertial_event_pkg::*;
(
  // Clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // Register access
  input regReq_type    regReq,
  input logic [7:0]    regRdData,
  // Samples and motion config
  input wire logic     sampleValid,
  input sample_type    sample,
  input motionCfg_type motionCfg,
  // Interrupts
  input logic          motionIrq,
  input logic          tiltIrq
);
  logic [15:0] thrQ, thrD;
  logic [7:0]  durQ, durD, cfgQ, cfgD;
  logic [16:0] magX;

  // Shadows follow host writes, so properties see live settings
  always_comb begin
    thrD = thrQ;
    durD = durQ;
    cfgD = cfgQ;
    if (regReq.wr && regReq.addr == 8'h34) thrD[7:0] = regReq.data;
    if (regReq.wr && regReq.addr == 8'h35) thrD[15:8] = regReq.data;
    if (regReq.wr && regReq.addr == 8'h36) durD = regReq.data;
    if (regReq.wr && regReq.addr == 8'h38) cfgD = regReq.data;
    magX = sample.x[15] ? 17'(~{1'b1, sample.x} + 17'h0_0001) : {1'b0, sample.x};
  end

  // Shadow registers
  always_ff @(posedge clk) begin
    thrQ <= rst ? 16'h0000 : thrD;
    durQ <= rst ? 8'h00 : durD;
    cfgQ <= rst ? 8'h00 : cfgD;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ack_reads_zero: assert property (
    regReq.rd && (regReq.addr == 8'h32 || regReq.addr == 8'h3A || regReq.addr == 8'h30)
    |=> regRdData == 8'h00) else $error("ack or unmapped read not zero");
  a_motion_ack_clear: assert property (
    regReq.rd && regReq.addr == 8'h32 && motionCfg.latch_request_select && !sampleValid
    |=> !motionIrq) else $error("motion ack read left irq set");
  a_tilt_ack_clear: assert property (
    regReq.rd && regReq.addr == 8'h3A && !$past(sampleValid) && !$past(regReq.wr)
    |=> !tiltIrq) else $error("tilt ack read left irq set");
  a_motion_irq_cause: assert property (
    $changed(motionIrq) |-> $past(sampleValid) || $past(regReq.rd && regReq.addr == 8'h32))
    else $error("motion irq moved without sample or ack");
  a_tilt_irq_cause: assert property (
    $rose(tiltIrq) |-> $past(sampleValid, 2) || $past(regReq.wr && regReq.addr == 8'h38)
    || $past(regReq.wr && regReq.addr == 8'h38, 2)) else $error("tilt irq rose without cause");
  a_tilt_irq_gate: assert property (
    tiltIrq |-> cfgQ[7]) else $error("tilt irq while change enable clear");
  a_dur_zero_fire: assert property (
    sampleValid && durQ == 8'h00 && !motionCfg.combine_and_or_select && motionCfg.xHigh
    && magX > {1'b0, thrQ} |=> motionIrq) else $error("zero duration did not fire");
  a_out_of_reset: assert property (
    $fell(rst) |-> !motionIrq && !tiltIrq && regRdData == 8'h00)
    else $error("outputs not clear after reset");

  // Main scenarios reached
  c_latched: cover property (motionIrq && motionCfg.latch_request_select);
  c_tilt: cover property ($rose(tiltIrq));
  c_filtered: cover property (sampleValid && durQ != 8'h00);
endmodule // inertial_event_detector_properties

bind inertial_event_detector inertial_event_detector_properties chk (
  .clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData), .sampleValid(sampleValid),
  .sample(sample), .motionCfg(motionCfg), .motionIrq(motionIrq), .tiltIrq(tiltIrq));

// ==== test/host_model.sv ====
// Host model issuing register writes and reads
`timescale 1ns/1ps
module host_model
  import inertial_event_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register access
  output regReq_type      regReq,
  input  wire logic [7:0] regRdData
);
  // Idle bus at start
  initial regReq = '0;

  // Write: drive after the edge, hold through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regReq = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    @(posedge clk);
    #1;
    regReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d}; // Released lines keep no stale value
  endtask

  // Read: ack addresses are how the host clears events
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regReq = '{rd: 1'b1, wr: 1'b0, addr: a, data: ~regReq.data};
    @(posedge clk);
    #1;
    d = regRdData;
    regReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~regReq.data};
  endtask
endmodule // host_model

// ==== test/tb_inertial_event_detector.sv ====
// Testbench of the inertial event detector
`timescale 1ns/1ps
module tb_inertial_event_detector import inertial_event_pkg::*;;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          sampleValid = 1'b0;
  sample_type    sample = '0;
  motionCfg_type motionCfg = '0;
  regReq_type    regReq;
  logic [7:0]    regRdData, rdv, dv;
  logic          motionIrq, tiltIrq, hit;
  logic [15:0]   thr, x;
  int            n_fail = 0;
  int            n_checks = 0;
  int            cnt;
  logic [7:0]    regs[8] = '{8'h34, 8'h35, 8'h36, 8'h38, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
  logic [7:0]    durs[2] = '{8'h03, 8'h00};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  host_model host (.clk(clk), .regReq(regReq), .regRdData(regRdData));
  inertial_event_detector dut (.clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .sampleValid(sampleValid), .sample(sample), .motionCfg(motionCfg),
    .motionIrq(motionIrq), .tiltIrq(tiltIrq));

  // Byte and bit comparisons
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkBit(string n, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    host.rd(a, rdv);
    chk8(n, e, rdv);
  endtask

  // Magnitude of a signed sample, one bit wider
  function automatic logic [16:0] mag(logic [15:0] v);
    return v[15] ? 17'(~{1'b1, v} + 17'h0_0001) : {1'b0, v};
  endfunction

  // One sample, Z mirrors Y; returns once the tilt source has settled
  task automatic smp(logic [15:0] sx, logic [15:0] sy);
    @(posedge clk);
    #1;
    sampleValid = 1'b1;
    sample = '{x: sx, y: sy, z: sy};
    @(posedge clk);
    #1;
    sampleValid = 1'b0;
    sample = ~sample;
    @(posedge clk);
    #1;
  endtask

  // Tilt step: sample, irq, source, then ack clears irq
  task automatic tstep(logic [15:0] sx, logic ei, logic [7:0] es);
    smp(sx, 16'h0000);
    chkBit("tiltIrq", ei, tiltIrq);
    rchk("tiltSrc", 8'h39, es);
    host.rd(8'h3A, rdv);
    chkBit("tiltIrqAck", 1'b0, tiltIrq);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog, far above the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hefeb_b717));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (regs[i]) rchk("resetVal", regs[i], 8'h00);
    rchk("unmapped", 8'h30, 8'h00);
    foreach (regs[i]) begin
      dv = 8'($urandom);
      host.wr(regs[i], dv);
      rchk("readback", regs[i], dv);
    end
    host.wr(8'h32, 8'hFF);
    rchk("ackRead", 8'h32, 8'h00);
    // Duration filter with random threshold and samples
    thr = 16'($urandom_range(16'h0100, 16'h3FFF));
    host.wr(8'h34, thr[7:0]);
    host.wr(8'h35, thr[15:8]);
    motionCfg = 8'h02;
    foreach (durs[d]) begin
      host.wr(8'h36, durs[d]);
      cnt = 0;
      for (int i = 0; i < 12; i++) begin
        x = (i % 4 == 3) ? (thr >> 1) : (i == 5) ? thr : 16'($urandom);
        hit = mag(x) > {1'b0, thr};
        cnt = hit ? cnt + 1 : 0;
        smp(x, 16'h0000);
        chkBit("motionIrq", hit && cnt >= int'(durs[d]), motionIrq);
      end
    end
    // Free-fall combine: all enabled flags needed
    motionCfg = 8'h86;
    smp(16'h7FFF, 16'h0000);
    chkBit("andTrue", 1'b1, motionIrq);
    motionCfg = 8'h20;
    smp(16'h0000, 16'h7FFF);
    chkBit("zHigh", 1'b1, motionIrq);
    motionCfg = 8'h86;
    smp(16'h7FFF, 16'h7FFF);
    chkBit("andFalse", 1'b0, motionIrq);
    // Latched motion event held until ack read
    motionCfg = 8'h42;
    smp(16'h8000, 16'h0000);
    smp(16'h0000, 16'h0000);
    chkBit("latched", 1'b1, motionIrq);
    rchk("motionSrc", 8'h31, 8'h42);
    host.rd(8'h32, rdv);
    chkBit("motionAck", 1'b0, motionIrq);
    motionCfg = 8'h00;
    // Tilt: inner 2000h, outer 4000h, both x directions
    host.wr(8'h3C, 8'h00);
    host.wr(8'h3D, 8'h20);
    host.wr(8'h3E, 8'h00);
    host.wr(8'h3F, 8'h40);
    host.wr(8'h38, 8'h83);
    host.rd(8'h3A, rdv);
    tstep(16'h5000, 1'b1, 8'h42);
    tstep(16'h3000, 1'b0, 8'h02);
    tstep(16'h1000, 1'b1, 8'h40);
    tstep(16'hB000, 1'b1, 8'h41);
    host.wr(8'h3D, 8'h60);
    tstep(16'h3000, 1'b1, 8'h40);
    // Change enable gates the line, not the active bit
    host.wr(8'h38, 8'h03);
    smp(16'h5000, 16'h0000);
    chkBit("gated", 1'b0, tiltIrq);
    host.wr(8'h38, 8'h83);
    chkBit("ungated", 1'b1, tiltIrq);
    host.rd(8'h3A, rdv);
    // Latch select holds the captured direction
    host.wr(8'h38, 8'hC3);
    smp(16'h1000, 16'h0000);
    smp(16'h5000, 16'h0000);
    rchk("tiltLatch", 8'h39, 8'h40);
    host.rd(8'h3A, rdv);
    // Positive enable off: leaving the high zone is no change
    host.wr(8'h38, 8'h81);
    smp(16'h5000, 16'h0000);
    host.rd(8'h3A, rdv);
    smp(16'h1000, 16'h0000);
    chkBit("masked", 1'b0, tiltIrq);
    tstep(16'hB000, 1'b1, 8'h41);
    stop_test();
  end
endmodule // tb_inertial_event_detector
